// [logic/tmr8_params.svh]
// Constants of the 8-bit waveform timer: register offsets, field
// positions, reset values, mode and tick-source codes.
// Assumes it is included by the package and by the timer module.
`ifndef TMR8_PARAMS_SVH
`define TMR8_PARAMS_SVH

// Byte addresses of the word registers on the register bus.
`define TMR_OFS_CTRL_A  8'h00
`define TMR_OFS_CTRL_B  8'h04
`define TMR_OFS_COUNT   8'h08
`define TMR_OFS_CMP_A   8'h0C
`define TMR_OFS_CMP_B   8'h10
`define TMR_OFS_MASK    8'h14
`define TMR_OFS_STATUS  8'h18
`define TMR_AW          8

// Counter limits.
`define TMR_MAX         8'hFF
`define TMR_BOT         8'h00

// Waveform mode codes.
`define TMR_WM_NORMAL   3'h0
`define TMR_WM_PC_FF    3'h1
`define TMR_WM_CTC      3'h2
`define TMR_WM_FAST_FF  3'h3
`define TMR_WM_PC_CMPA  3'h5
`define TMR_WM_FAST_CMPA 3'h7

// Tick source codes.
`define TMR_CS_STOP     3'h0
`define TMR_CS_DIV1     3'h1
`define TMR_CS_DIV8     3'h2
`define TMR_CS_DIV64    3'h3
`define TMR_CS_DIV256   3'h4
`define TMR_CS_DIV1024  3'h5
`define TMR_CS_EXT_FALL 3'h6
`define TMR_CS_EXT_RISE 3'h7
`define TMR_PSC_W       10

// Field positions.
`define TMR_COMA_HI     7
`define TMR_COMB_HI     5
`define TMR_FOCA        7
`define TMR_FOCB        6
`define TMR_WGM2        3
`define TMR_ST_TOV      0
`define TMR_ST_CMPA     1
`define TMR_ST_CMPB     2

// Write masks, reset values and bus answers.
`define TMR_CTRL_A_WMASK 8'hF3
`define TMR_RST_BYTE    8'h00
`define TMR_RESP_OKAY   2'h0
`define TMR_RESP_SLVERR 2'h2

`endif

// [logic/tmr8_pkg.sv]
// Types of the 8-bit waveform timer: the packed state record.
// Assumes tmr8_params.svh is on the include path.
`include "tmr8_params.svh"

package tmr8_pkg;

	// Whole state of the timer and its bus slave.
	typedef struct packed {
		logic [7:0]                 ctrl_a;   // Output actions and low mode bits.
		logic [3:0]                 ctrl_b;   // High mode bit and tick source.
		logic [7:0]                 cnt;      // Counter value.
		logic                       dn;       // Counting down in phase-correct mode.
		logic                       blk;      // Match blocked after a counter write.
		logic [1:0][7:0]            ocr_buf;  // Compare values as written.
		logic [1:0][7:0]            ocr_act;  // Compare values in use.
		logic [1:0]                 wave;     // Waveform outputs.
		logic [2:0]                 st;       // Sticky event flags.
		logic [2:0]                 msk;      // Interrupt mask.
		logic [`TMR_PSC_W-1:0]      psc;      // Prescaler count.
		logic                       s1;       // External pin synchroniser.
		logic                       s2;
		logic                       s3;
		logic                       ext_q;    // Filtered external pin level.
		logic                       bvalid;   // Write answer pending.
		logic [1:0]                 bresp;
		logic                       rvalid;   // Read answer pending.
		logic [1:0]                 rresp;
		logic [31:0]                rdata;
		logic [1:0]                 pin;      // Pin output levels.
		logic [1:0]                 oe;       // Pin output enables.
		logic                       irq;      // Interrupt level.
	} tmr_state_s;

endpackage

// [logic/tmr8_wave_timer.sv]
// 8-bit timer with two compare channels, waveform outputs, pin
// override, prescaler, interrupt flags and an AXI4-Lite slave.
// Assumes one clock, an async active-low reset and a port block that
// supplies the normal pin level and direction bit for each channel.
//
// How it works
// - Counter runs on system clock, tick enables.
// - Nonzero action A routes wave A to pin; PWM 01 needs mode bit2.
// - Nonzero action B routes wave B to pin.
// - Non-PWM A: off, toggle, clear, set on match.
// - Fast PWM A: 01 toggles if mode bit2.
// - Phase PWM A: clear up, set down match.
// - Non-PWM B: off, toggle, clear, set on match.
// - Fast PWM B: clear match, set top; 01 reserved.
// - Phase PWM B: clear up, set down; 01 reserved.
// - Compare equal top: ignore match, act at top.
// - Mode is three bits from two registers.
// - Modes 0,2: immediate compare, overflow at max.
// - PWM: compare updated at top; overflow per mode.
// - Maximum 0xFF; top 0xFF or compare A.
// - Compare A top in modes 2,7: flag and clear next tick.
// - Control A bits 3,2 ignored, read zero.
// - Tick source: stop, divided clock, external edge.
// - Force strobe applies action outside PWM, no flag, reads zero.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "tmr8_params.svh"

module tmr8_wave_timer
	import tmr8_pkg::*;
(
	input  wire logic              clock_i,
	input  wire logic              rstn_i,
	input  wire logic [`TMR_AW-1:0] s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	input  wire logic [`TMR_AW-1:0] s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	input  wire logic              ext_tick_pin_i,
	input  wire logic [1:0]        port_out_i,
	input  wire logic [1:0]        port_dir_i,
	output logic [1:0]             wave_out_o,
	output logic [1:0]             pin_o,
	output logic [1:0]             pin_oe_o,
	output logic                   irq_o
);
	import tmr8_pkg::*;

	tmr_state_s s;        // Registered state.
	tmr_state_s n;        // Next state.

	logic       tick;     // Timer tick enable, one cycle.
	logic [2:0] mode;     // Waveform mode.
	logic       pwm;      // Either PWM mode.
	logic       fast;     // Fast PWM mode.
	logic       phase;    // Phase-correct PWM mode.
	logic [7:0] top;      // Top value of the count.
	logic       at_top;   // Counter is at top.
	logic [1:0] mt;       // Compare match on this tick.
	logic [1:0] frc;      // Force strobes.
	logic [1:0] com;      // Output action of the channel in hand.
	logic [2:0] w1c;      // Flags cleared by software.
	logic [2:0] evt;      // Flags set by hardware.
	logic       cnt_wr;   // Software writes the counter.
	logic       stable;   // External pin settled.
	logic       wr;       // Write taken.
	logic       rd;       // Read taken.
	logic [7:0] wa;       // Word-aligned write address.
	logic [7:0] ra;       // Word-aligned read address.

	// Handshake outputs follow the pending answers.
	assign wr = s_axi_awvalid_i & s_axi_wvalid_i & ~s.bvalid;
	assign rd = s_axi_arvalid_i & ~s.rvalid;
	assign s_axi_awready_o = wr;
	assign s_axi_wready_o  = wr;
	assign s_axi_arready_o = rd;
	assign wa = {s_axi_awaddr_i[`TMR_AW-1:2], 2'h0};
	assign ra = {s_axi_araddr_i[`TMR_AW-1:2], 2'h0};

	// Mode decode from both control registers.
	assign mode  = {s.ctrl_b[`TMR_WGM2], s.ctrl_a[1:0]};
	assign pwm   = mode[0];
	assign fast  = mode[1:0] == 2'h3;
	assign phase = mode[1:0] == 2'h1;
	// Top follows compare A in modes 2, 5 and 7.
	assign top = (mode == `TMR_WM_CTC || mode == `TMR_WM_PC_CMPA
		|| mode == `TMR_WM_FAST_CMPA) ? s.ocr_act[0] : `TMR_MAX;
	assign at_top = s.cnt == top;
	assign stable = s.s2 == s.s3;

	// Next-state logic for the whole block.
	always_comb
	begin
		n      = s;
		tick   = 1'b0;
		mt     = 2'h0;
		frc    = 2'h0;
		com    = 2'h0;
		w1c    = 3'h0;
		evt    = 3'h0;
		cnt_wr = 1'b0;

		// External pin passes three flops; it counts when two agree.
		n.s1 = ext_tick_pin_i;
		n.s2 = s.s1;
		n.s3 = s.s2;
		if (stable)
		begin
			n.ext_q = s.s3;
		end

		// Prescaler runs free; the tick source picks one tap.
		n.psc = s.psc + 1'b1;
		case (s.ctrl_b[2:0])
			`TMR_CS_DIV1:     tick = 1'b1;
			`TMR_CS_DIV8:     tick = &s.psc[2:0];
			`TMR_CS_DIV64:    tick = &s.psc[5:0];
			`TMR_CS_DIV256:   tick = &s.psc[7:0];
			`TMR_CS_DIV1024:  tick = &s.psc[9:0];
			`TMR_CS_EXT_FALL: tick = stable & ~s.s3 & s.ext_q;
			`TMR_CS_EXT_RISE: tick = stable & s.s3 & ~s.ext_q;
			default:          tick = 1'b0;
		endcase

		// Compare match on a tick, unless a counter write blocks it.
		for (int c = 0; c < 2; c++)
		begin
			mt[c] = tick & ~s.blk & (s.cnt == s.ocr_act[c]);
		end
		if (tick)
		begin
			n.blk = 1'b0;
		end

		// Write channel: both halves are taken together.
		if (wr)
		begin
			n.bvalid = 1'b1;
			n.bresp  = (wa <= `TMR_OFS_STATUS) ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
			if (s_axi_wstrb_i[0])
			begin
				case (wa)
					`TMR_OFS_CTRL_A:
					begin
						// Reserved bits are never stored.
						n.ctrl_a = s_axi_wdata_i[7:0] & `TMR_CTRL_A_WMASK;
					end
					`TMR_OFS_CTRL_B:
					begin
						n.ctrl_b = s_axi_wdata_i[3:0];
						// Strobes act only outside PWM and are not stored.
						frc[0] = s_axi_wdata_i[`TMR_FOCA] & ~pwm;
						frc[1] = s_axi_wdata_i[`TMR_FOCB] & ~pwm;
					end
					`TMR_OFS_COUNT:
					begin
						n.cnt  = s_axi_wdata_i[7:0];
						n.blk  = 1'b1;
						cnt_wr = 1'b1;
					end
					`TMR_OFS_CMP_A:  n.ocr_buf[0] = s_axi_wdata_i[7:0];
					`TMR_OFS_CMP_B:  n.ocr_buf[1] = s_axi_wdata_i[7:0];
					`TMR_OFS_MASK:   n.msk = s_axi_wdata_i[2:0];
					`TMR_OFS_STATUS: w1c = s_axi_wdata_i[2:0];
					default:         n.bvalid = 1'b1;
				endcase
			end
		end
		else if (s.bvalid && s_axi_bready_i)
		begin
			n.bvalid = 1'b0;
		end

		// Read channel: the answer follows one cycle after the address.
		if (rd)
		begin
			n.rvalid = 1'b1;
			n.rresp  = `TMR_RESP_OKAY;
			n.rdata  = 32'h0000_0000;
			case (ra)
				`TMR_OFS_CTRL_A: n.rdata[7:0] = s.ctrl_a;
				`TMR_OFS_CTRL_B: n.rdata[3:0] = s.ctrl_b;
				`TMR_OFS_COUNT:  n.rdata[7:0] = s.cnt;
				`TMR_OFS_CMP_A:  n.rdata[7:0] = s.ocr_buf[0];
				`TMR_OFS_CMP_B:  n.rdata[7:0] = s.ocr_buf[1];
				`TMR_OFS_MASK:   n.rdata[2:0] = s.msk;
				`TMR_OFS_STATUS: n.rdata[2:0] = s.st;
				default:         n.rresp = `TMR_RESP_SLVERR;
			endcase
		end
		else if (s.rvalid && s_axi_rready_i)
		begin
			n.rvalid = 1'b0;
		end

		// Counter steps only on a tick; a software write wins.
		if (tick && !cnt_wr)
		begin
			if (phase)
			begin
				// Dual slope: up to top, then down to bottom.
				if (!s.dn)
				begin
					if (at_top)
					begin
						n.dn  = 1'b1;
						n.cnt = s.cnt - 8'h01;
					end
					else
					begin
						n.cnt = s.cnt + 8'h01;
					end
				end
				else if (s.cnt == `TMR_BOT)
				begin
					n.dn  = 1'b0;
					n.cnt = s.cnt + 8'h01;
					evt[`TMR_ST_TOV] = 1'b1;
				end
				else
				begin
					n.cnt = s.cnt - 8'h01;
				end
			end
			else
			begin
				n.dn = 1'b0;
				// Clear at top in CLEAR_ON_COMPARE_MODE and fast modes.
				if (at_top && mode != `TMR_WM_NORMAL)
				begin
					n.cnt = `TMR_BOT;
				end
				else
				begin
					n.cnt = s.cnt + 8'h01;
				end
				if (mode == `TMR_WM_FAST_CMPA)
				begin
					evt[`TMR_ST_TOV] = at_top;
				end
				else
				begin
					evt[`TMR_ST_TOV] = s.cnt == `TMR_MAX;
				end
			end
		end

		// Compare values: double-buffered in PWM, immediate otherwise.
		if (!pwm)
		begin
			n.ocr_act = n.ocr_buf;
		end
		else if (tick && at_top)
		begin
			n.ocr_act = s.ocr_buf;
		end

		// Waveform actions per channel; flops move on tick or force.
		for (int c = 0; c < 2; c++)
		begin
			com = (c == 0) ? s.ctrl_a[`TMR_COMA_HI -: 2] : s.ctrl_a[`TMR_COMB_HI -: 2];
			case (com)
				2'h1:
				begin
					// Toggle outside PWM; in PWM only A with mode bit 2.
					if ((!pwm || (c == 0 && mode[2])) && (mt[c] || frc[c]))
					begin
						n.wave[c] = ~s.wave[c];
					end
				end
				2'h2, 2'h3:
				begin
					if (!pwm)
					begin
						// Clear or set on match or force.
						if (mt[c] || frc[c])
						begin
							n.wave[c] = com[0];
						end
					end
					else if (fast)
					begin
						// Match drives com[0]; top drives the inverse.
						if (tick && at_top)
						begin
							n.wave[c] = ~com[0];
						end
						else if (mt[c] && s.ocr_act[c] != top)
						begin
							n.wave[c] = com[0];
						end
					end
					else
					begin
						// Up match drives com[0]; down match the inverse.
						if (tick && at_top && s.ocr_act[c] == top)
						begin
							n.wave[c] = ~com[0];
						end
						else if (mt[c] && s.ocr_act[c] != top)
						begin
							n.wave[c] = s.dn ? ~com[0] : com[0];
						end
					end
				end
				default:
				begin
					n.wave[c] = s.wave[c];
				end
			endcase

			// Pin takes the waveform while the action field is nonzero.
			// In PWM, code 01 on channel A keeps the port unless mode bit 2 is set.
			n.pin[c] = ((|com) && !(c == 0 && com == 2'h1 && pwm && !mode[2]))
				? s.wave[c] : port_out_i[c];
			n.oe[c]  = port_dir_i[c];
		end

		// Compare flags; a force strobe never sets one.
		evt[`TMR_ST_CMPA] = mt[0];
		evt[`TMR_ST_CMPB] = mt[1];
		// A new event wins over a clear in the same cycle.
		n.st  = (s.st & ~w1c) | evt;
		n.irq = |(n.st & n.msk);
	end

	// State register.
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			s <= '0;
		end
		else
		begin
			s <= n;
		end
	end

	// Outputs come straight from the state register.
	assign s_axi_bvalid_o = s.bvalid;
	assign s_axi_bresp_o  = s.bresp;
	assign s_axi_rvalid_o = s.rvalid;
	assign s_axi_rresp_o  = s.rresp;
	assign s_axi_rdata_o  = s.rdata;
	assign wave_out_o     = s.wave;
	assign pin_o          = s.pin;
	assign pin_oe_o       = s.oe;
	assign irq_o          = s.irq;

	// Checks on the timer behaviour.
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);

	a_stop_no_tick: assert property (s.ctrl_b[2:0] == `TMR_CS_STOP |-> !tick)
		else $error("Tick while the timer is stopped.");
	a_div1_tick: assert property (s.ctrl_b[2:0] == `TMR_CS_DIV1 |-> tick)
		else $error("Undivided source gave no tick.");
	a_count_hold: assert property (!tick && !cnt_wr |=> $stable(s.cnt))
		else $error("Counter moved without a tick.");
	a_wave_hold: assert property (!tick && frc == 2'h0 |=> $stable(s.wave))
		else $error("Waveform changed between ticks.");
	a_ctrla_resv: assert property (s.ctrl_a[3:2] == 2'h0)
		else $error("Reserved control bits were stored.");
	a_force_noflag: assert property (frc != 2'h0 && !tick && w1c == 3'h0 |=> $stable(s.st))
		else $error("Force strobe raised a flag.");
	a_ctc_clear: assert property (tick && !cnt_wr && mode == `TMR_WM_CTC && at_top && !s.blk
		|=> s.cnt == `TMR_BOT && s.st[`TMR_ST_CMPA])
		else $error("Clear on compare A failed.");
	a_tov_normal: assert property (tick && !cnt_wr && mode == `TMR_WM_NORMAL
		&& s.cnt == `TMR_MAX |=> s.st[`TMR_ST_TOV] && s.cnt == `TMR_BOT)
		else $error("Overflow flag missed at maximum.");
	a_pin_a_route: assert property (1'b1 |=> s.pin[0] == ($past(|s.ctrl_a[7:6]
		&& !(s.ctrl_a[7:6] == 2'h1 && s.ctrl_a[0] && !s.ctrl_b[`TMR_WGM2]))
		? $past(s.wave[0]) : $past(port_out_i[0])))
		else $error("Pin A routing wrong.");
	a_pin_b_route: assert property (1'b1 |=> s.pin[1] == ($past(|s.ctrl_a[5:4])
		? $past(s.wave[1]) : $past(port_out_i[1])))
		else $error("Pin B routing wrong.");
	a_cmp_buffered: assert property (pwm && !(tick && at_top) |=> $stable(s.ocr_act))
		else $error("Compare value changed away from top.");

	c_ctc_wrap: cover property (tick && mode == `TMR_WM_CTC && at_top ##1 s.cnt == `TMR_BOT);
	c_fast_top: cover property (tick && fast && at_top && s.ctrl_a[7]);
	c_phase_turn: cover property (tick && phase && s.dn && s.cnt == `TMR_BOT);
	c_force_a: cover property (frc[0]);

endmodule // tmr8_wave_timer

// [sim/tmr8_pad_model.sv]
// Pad model for the two pins that the timer can take over.
// Assumes the timer's registered pin level and output enable, one clock.
`timescale 1ns/1ps

module tmr8_pad_model
(
	input  wire logic       clock_i,
	input  wire logic [1:0] pin_i,
	input  wire logic [1:0] oe_i,
	output logic [1:0]      pad_o
);
	// Level of an undriven pad; it flips every cycle so a stale value never passes.
	logic [1:0] float_r = 2'h1;

	// The floating pattern has no pull and no memory of the last driven level.
	always_ff @(posedge clock_i)
	begin
		float_r <= ~float_r;
	end

	// A pad shows the timer's level only while its driver is enabled.
	always_comb
	begin
		pad_o = (oe_i & pin_i) | (~oe_i & float_r);
	end
endmodule // tmr8_pad_model

// [sim/tb_timer8_waveform_compare_control.sv]
// Self-checking bench for the 8-bit waveform timer and its register slave.
// Assumes tmr8_params.svh on the include path and the pad model beside it.
`timescale 1ns/1ps
`include "tmr8_params.svh"

module tb_timer8_waveform_compare_control;
	import tmr8_pkg::*;
	logic        clock_i = 1'b0;  // System clock, 50 ns period.
	logic        rstn_i = 1'b0;   // Active-low reset.
	logic [7:0]  awaddr = '0;     // Bus master signals.
	logic [7:0]  araddr = '0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        arvalid = 1'b0;
	logic        bready = 1'b1;   // Answers are always accepted.
	logic        rready = 1'b1;
	logic [31:0] wdata = '0;
	logic [3:0]  wstrb = 4'hF;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp, wave, pin, oe, pad;
	logic [31:0] rdata;
	logic        ext_pin = 1'b0;  // External tick source.
	logic [1:0]  port_out = 2'h0; // Normal port levels.
	logic [1:0]  port_dir = 2'h0; // Direction bits.
	logic [31:0] rd_data;         // Last read answer.
	logic [1:0]  resp;            // Last bus response.
	logic [1:0]  wave_m = 2'h0;   // Model of the waveform flops.
	int          mismatches = 0;
	int          checked = 0;
	int          cyc = 0;
	int          acts[6] = '{3, 1, 2, 1, 1, 3};
	int          divs[6] = '{0, 1, 8, 64, 256, 1024};
	int          fmode[3] = '{0, 2, 7};
	int          fexp[3] = '{7, 2, 3};

	tmr8_wave_timer uut (.clock_i(clock_i), .rstn_i(rstn_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ext_tick_pin_i(ext_pin),
		.port_out_i(port_out), .port_dir_i(port_dir), .wave_out_o(wave), .pin_o(pin),
		.pin_oe_o(oe), .irq_o(irq));

	tmr8_pad_model pads (.clock_i(clock_i), .pin_i(pin), .oe_i(oe), .pad_o(pad));

	// Clock generator.
	always #25 clock_i = ~clock_i;

	// Cycle counter that cuts a hang short.
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			mismatches++;
			final_report();
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Compares a bus word.
	task automatic chk_data(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// Compares a two-bit port value or response.
	task automatic chk_bits(input string n, input logic [1:0] e, input logic [1:0] g);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// Waits a number of cycles.
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	// Write: each valid drops at its own taking edge, then wait for the answer.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ad;
		bit wd;
		ad = 0;
		wd = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge clock_i);
			if (awready === 1'b1)
			begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1)
			begin
				wd = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clock_i); while (bvalid !== 1'b1);
		resp = bresp;
	endtask

	// Read: hold the address until taken, then take data at the answer edge.
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clock_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clock_i); while (rvalid !== 1'b1);
		rd_data = rdata;
		resp = rresp;
	endtask

	// Main sequence.
	initial
	begin
		int aa;
		int bb;
		int md;
		int n;
		logic [31:0] rnd;
		void'($urandom(16));
		tick(6);
		rstn_i <= 1'b1;
		tick(1);
		// Reset values of every register, then one unmapped word.
		for (int i = 0; i < 8; i++)
		begin
			rd(8'(i * 4));
			chk_data("reset read", 32'h0, rd_data);
			chk_bits("read resp", (i == 7) ? 2'h2 : 2'h0, resp);
		end
		wr(8'h1C, 32'hFF);
		chk_bits("unmapped write resp", 2'h2, resp);
		wr(8'h00, 32'hFF);
		rd(8'h00);
		chk_data("ctrl_a", 32'hF3, rd_data);
		wr(8'h00, 32'h0);
		// Compare values read back as written in normal mode.
		for (int i = 0; i < 2; i++)
		begin
			rnd = $urandom();
			wr(8'(12 + i * 4), rnd);
			rd(8'(12 + i * 4));
			chk_data("compare", rnd & 32'hFF, rd_data);
		end
		// Force strobes with the toggle, clear and set actions on both channels.
		port_dir <= 2'h3;
		for (int i = 0; i < 6; i++)
		begin
			aa = acts[i];
			bb = acts[5 - i];
			port_out <= 2'($urandom());
			wr(8'h00, 32'(aa * 64 + bb * 16));
			wr(8'h04, 32'hC0);
			wave_m[0] = (aa == 1) ? ~wave_m[0] : (aa == 3);
			wave_m[1] = (bb == 1) ? ~wave_m[1] : (bb == 3);
			chk_bits("wave", wave_m, wave);
			rd(8'h04);
			chk_data("ctrl_b", 32'h0, rd_data);
			tick(2);
			chk_bits("pin", wave_m, pin);
			chk_bits("pad", wave_m, pad);
		end
		rd(8'h18);
		chk_data("status after force", 32'h0, rd_data);
		// Disconnected outputs give the pins back to the port.
		wr(8'h00, 32'h0);
		rnd = $urandom();
		port_dir <= rnd[1:0];
		tick(3);
		chk_bits("pin port", port_out, pin);
		chk_bits("oe", rnd[1:0], oe);
		wr(8'h00, 32'h43);
		tick(3);
		chk_bits("fast toggle off", {1'b0, port_out[0]}, {1'b0, pin[0]});
		// PWM with compare equal to top: steady level from the top action.
		wr(8'h0C, 32'hFF);
		wr(8'h10, 32'hFF);
		for (int j = 0; j < 4; j++)
		begin
			md = (j < 2) ? 3 : 1;
			aa = 2 + j % 2;
			wr(8'h00, 32'(aa * 80 + md));
			wr(8'h04, 32'h1);
			tick(1100);
			repeat (20)
			begin
				tick(13);
				chk_bits("pwm wave", {2{~aa[0]}}, wave);
			end
			wr(8'h04, 32'h0);
		end
		// Flags per mode, interrupt raise, mask and clear.
		wr(8'h14, 32'h1);
		for (int k = 0; k < 3; k++)
		begin
			md = fmode[k];
			wr(8'h04, 32'h0);
			wr(8'h0C, 32'h20);
			wr(8'h00, 32'(md % 4));
			wr(8'h04, 32'((md / 4) * 8 + 1));
			tick(600);
			wr(8'h18, 32'h7);
			tick(300);
			wr(8'h04, 32'((md / 4) * 8));
			rd(8'h18);
			chk_data("status", 32'(fexp[k]), rd_data);
			chk_bits("irq", {1'b0, rd_data[0]}, {1'b0, irq});
			rd(8'h08);
			chk_data("count bound", 32'h1, 32'((md == 0) || (rd_data <= 32'h20)));
			wr(8'h14, 32'h0);
			tick(2);
			chk_bits("irq masked", 2'h0, {1'b0, irq});
			wr(8'h14, 32'h1);
			wr(8'h18, 32'h7);
			tick(2);
			chk_bits("irq cleared", 2'h0, {1'b0, irq});
		end
		// Tick sources: stopped, the divided clocks, then both external edges.
		wr(8'h00, 32'h0);
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h04, 32'h0);
			wr(8'h08, 32'h0);
			wr(8'h04, 32'(c));
			if (c < 6)
				tick(8 * ((c == 0) ? 1 : divs[c]));
			else
			begin
				repeat (5)
				begin
					tick(10);
					ext_pin <= 1'b1;
					tick(10);
					ext_pin <= 1'b0;
				end
				// Let the last pin edge pass the synchroniser before stopping.
				tick(10);
			end
			wr(8'h04, 32'h0);
			rd(8'h08);
			n = (c == 0) ? 0 : (c > 5) ? 5 : 8;
			aa = (c == 0 || c > 5) ? 0 : 1 + 8 / divs[c];
			chk_data("tick count", 32'h1, 32'(rd_data + aa >= n && rd_data <= n + aa));
		end
		final_report();
	end
endmodule // tb_timer8_waveform_compare_control
